// [design/gpx_pkg.sv]
// Purpose: Shared constants and types for the I2C-controlled 8-pin expander core
// Assumes: One system clock; bus pins and port pins are sampled through synchronisers
// Notes:   Pointer codes double as register offsets on the serial bus
package gpx_pkg;

  localparam int PINS = 8;

  // Pointer codes (register offsets)
  localparam logic [7:0] PTR_IN        = 8'h00;
  localparam logic [7:0] PTR_OUT       = 8'h01;
  localparam logic [7:0] PTR_INV       = 8'h02;
  localparam logic [7:0] PTR_DIR       = 8'h03;
  localparam logic [7:0] PTR_DRV_LO    = 8'h40;
  localparam logic [7:0] PTR_DRV_HI    = 8'h41;
  localparam logic [7:0] PTR_HOLD      = 8'h42;
  localparam logic [7:0] PTR_BIAS_EN   = 8'h43;
  localparam logic [7:0] PTR_BIAS_SEL  = 8'h44;
  localparam logic [7:0] PTR_IRQ_MASK  = 8'h45;
  localparam logic [7:0] PTR_IRQ_FLAGS = 8'h46;
  localparam logic [7:0] PTR_OSTAGE    = 8'h4f;

  // Reset values
  localparam logic [7:0] RST_OUT       = 8'hff;
  localparam logic [7:0] RST_INV       = 8'h00;
  localparam logic [7:0] RST_DIR       = 8'hff;
  localparam logic [7:0] RST_DRV       = 8'hff;
  localparam logic [7:0] RST_HOLD      = 8'h00;
  localparam logic [7:0] RST_BIAS_EN   = 8'h00;
  localparam logic [7:0] RST_BIAS_SEL  = 8'hff;
  localparam logic [7:0] RST_IRQ_MASK  = 8'hff;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_OSTAGE    = 8'h00;
  localparam logic [7:0] OSTAGE_MASK   = 8'h01;
  localparam logic [7:0] READ_NONE     = 8'h00;

  // Bus address: fixed upper bits, then two select pins, then direction bit
  localparam logic [4:0] BUS_ADDR_FIXED = 5'h1c;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_TX_SHIFT  = 4'h7;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK  = 6'h04,
    S_WR   = 6'h08,
    S_RD   = 6'h10,
    S_RACK = 6'h20
  } bus_state_e;

  typedef struct packed {
    logic [7:0] out_latch;
    logic [7:0] invert;
    logic [7:0] direction;
    logic [7:0] drive_lo;
    logic [7:0] drive_hi;
    logic [7:0] hold_en;
    logic [7:0] bias_en;
    logic [7:0] bias_sel;
    logic [7:0] irq_mask;
    logic [7:0] ostage;
  } regfile_s;

  localparam regfile_s REGS_RST = '{
    out_latch: RST_OUT,      invert:  RST_INV,      direction: RST_DIR,
    drive_lo:  RST_DRV,      drive_hi: RST_DRV,     hold_en:   RST_HOLD,
    bias_en:   RST_BIAS_EN,  bias_sel: RST_BIAS_SEL, irq_mask: RST_IRQ_MASK,
    ostage:    RST_OSTAGE
  };

  // Raw pin group carried through the synchroniser
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [1:0] addr_sel;
    logic [7:0] pins;
  } pin_sample_s;

  localparam pin_sample_s PIN_RST = '{scl: 1'b1, sda: 1'b1, addr_sel: 2'h0, pins: 8'h00};

  typedef struct packed {
    bus_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rw;
    logic       got_cmd;
    logic       sda_oe;
    logic       scl_q;
    logic       sda_q;
    regfile_s   regs;
  } core_state_s;

  localparam core_state_s CORE_RST = '{
    st: S_IDLE, cnt: 4'h0, sh: 8'h00, ptr: PTR_IN, rw: 1'b0, got_cmd: 1'b0,
    sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1, regs: REGS_RST
  };

endpackage

// [design/pin_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: Inputs change slowly compared with the system clock
// Notes:   Output follows only once the second and third stages agree
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int             W       = 12,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_s;

  sync_state_s st_r;
  sync_state_s st_nxt;

  // Elaboration-time refusal of a width the filter cannot serve
  if (W < 1) begin
    $error("pin_sync3: width must be at least one");
  end

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Bitwise: a bit moves only where the two later stages agree
    st_nxt.q  = (st_r.q & ~(st_r.s2 ~^ st_r.s3)) | (st_r.s3 & (st_r.s2 ~^ st_r.s3));
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;

endmodule

// [design/i2c_gpio_expander_regs.sv]
// Purpose: Serial-bus slave, register file and pin control of an 8-pin expander
// Assumes: Bus clock far below clk_sys_i; pins and bus lines are asynchronous
// Notes:   Data bytes after the pointer byte all target the same pointer
// Functional notes
// - Input register shows live level of every pin, input or output
// - Input register is read-only; writes to it change nothing
// - Input register has no reset value; it follows the pins
// - Output latch drives a pin only while that pin is an output
// - Reading the output latch returns the written value, not the pins
// - Invert bit set flips the sensed level of an input pin
// - Direction one makes the pin a high-impedance input, zero an output
// - Two-bit drive code per pin: quarter, half, three quarters, full
// - Pins 0-3 drive codes in low register, 4-7 in high, pin 7 at 7:6
// - First byte after a write address is stored as the register pointer
// - Address byte last bit: one reads, zero writes
`timescale 1ns/1ns
module i2c_gpio_expander_regs
  import gpx_pkg::*;
#(
  parameter int NPINS = PINS
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              addr_select_bit0_i,
  input  wire logic              addr_select_bit1_i,
  input  wire logic [NPINS-1:0]  gpio_i,
  output logic      [NPINS-1:0]  gpio_o,
  output logic      [NPINS-1:0]  gpio_oe_o,
  output logic      [2*NPINS-1:0] drive_code_o
);

  if (NPINS != PINS) begin
    $error("expander: register layout serves exactly eight pins");
  end

  core_state_s q_r;
  core_state_s q_nxt;
  pin_sample_s raw;
  pin_sample_s smp;
  logic [7:0]  sensed;
  logic [7:0]  rd_val;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        byte_done;
  logic        addr_hit;
  logic        reg_wr;
  logic        ptr_wr;
  logic        rd_load;

  function automatic logic [7:0] reg_read(input logic [7:0] p,
                                          input regfile_s   r,
                                          input logic [7:0] live);
    case (p)
      PTR_IN:        reg_read = live;
      PTR_OUT:       reg_read = r.out_latch;
      PTR_INV:       reg_read = r.invert;
      PTR_DIR:       reg_read = r.direction;
      PTR_DRV_LO:    reg_read = r.drive_lo;
      PTR_DRV_HI:    reg_read = r.drive_hi;
      PTR_HOLD:      reg_read = r.hold_en;
      PTR_BIAS_EN:   reg_read = r.bias_en;
      PTR_BIAS_SEL:  reg_read = r.bias_sel;
      PTR_IRQ_MASK:  reg_read = r.irq_mask;
      PTR_IRQ_FLAGS: reg_read = RST_IRQ_FLAGS;
      PTR_OSTAGE:    reg_read = r.ostage;
      default:       reg_read = READ_NONE;
    endcase
  endfunction

  function automatic regfile_s reg_write(input logic [7:0] p,
                                         input regfile_s   r,
                                         input logic [7:0] d);
    regfile_s w;
    w = r;
    case (p)
      PTR_OUT:      w.out_latch = d;
      PTR_INV:      w.invert    = d;
      PTR_DIR:      w.direction = d;
      PTR_DRV_LO:   w.drive_lo  = d;
      PTR_DRV_HI:   w.drive_hi  = d;
      PTR_HOLD:     w.hold_en   = d;
      PTR_BIAS_EN:  w.bias_en   = d;
      PTR_BIAS_SEL: w.bias_sel  = d;
      PTR_IRQ_MASK: w.irq_mask  = d;
      PTR_OSTAGE:   w.ostage    = d & OSTAGE_MASK;
      // Input and status codes are read-only; unmapped codes are dropped
      default:      w = r;
    endcase
    return w;
  endfunction

  assign raw.scl      = scl_i;
  assign raw.sda      = sda_i;
  assign raw.addr_sel = {addr_select_bit1_i, addr_select_bit0_i};
  assign raw.pins     = gpio_i;

  pin_sync3 #(
    .W       ($bits(pin_sample_s)),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .d_i       (raw),
    .q_o       (smp)
  );

  // Inversion applies to input pins only; output pins read back raw
  assign sensed     = smp.pins ^ (q_r.regs.invert & q_r.regs.direction);
  assign rd_val     = reg_read(q_r.ptr, q_r.regs, sensed);
  assign scl_rise   = !q_r.scl_q && smp.scl;
  assign scl_fall   = q_r.scl_q && !smp.scl;
  assign start_cond = q_r.scl_q && smp.scl && q_r.sda_q && !smp.sda;
  assign stop_cond  = q_r.scl_q && smp.scl && !q_r.sda_q && smp.sda;
  assign byte_done  = scl_fall && (q_r.cnt == BITS_PER_BYTE);
  assign addr_hit   = (q_r.sh[7:1] == {BUS_ADDR_FIXED, smp.addr_sel});
  assign ptr_wr     = (q_r.st == S_WR) && byte_done && !q_r.got_cmd;
  assign reg_wr     = (q_r.st == S_WR) && byte_done && q_r.got_cmd;
  assign rd_load    = scl_fall && q_r.rw && (q_r.st == S_ACK);

  always_comb begin
    q_nxt       = q_r;
    q_nxt.scl_q = smp.scl;
    q_nxt.sda_q = smp.sda;
    if (start_cond) begin
      // Repeated start keeps the pointer so a read can follow a pointer write
      q_nxt.st      = S_ADDR;
      q_nxt.cnt     = 4'h0;
      q_nxt.got_cmd = 1'b0;
      q_nxt.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      q_nxt.st     = S_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else begin
      case (q_r.st)
        S_IDLE: begin
          q_nxt.sda_oe = 1'b0;
        end
        S_ADDR, S_WR: begin
          if (scl_rise) begin
            q_nxt.sh  = {q_r.sh[6:0], smp.sda};
            q_nxt.cnt = q_r.cnt + 4'h1;
          end else if (byte_done) begin
            if (q_r.st == S_ADDR) begin
              if (addr_hit) begin
                q_nxt.rw     = q_r.sh[0];
                q_nxt.sda_oe = 1'b1;
                q_nxt.st     = S_ACK;
              end else begin
                q_nxt.st = S_IDLE;
              end
            end else begin
              if (!q_r.got_cmd) begin
                q_nxt.ptr     = q_r.sh;
                q_nxt.got_cmd = 1'b1;
              end else begin
                q_nxt.regs = reg_write(q_r.ptr, q_r.regs, q_r.sh);
              end
              q_nxt.sda_oe = 1'b1;
              q_nxt.st     = S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            q_nxt.cnt = 4'h0;
            if (q_r.rw) begin
              q_nxt.sh     = rd_val;
              q_nxt.sda_oe = ~rd_val[7];
              q_nxt.st     = S_RD;
            end else begin
              q_nxt.sda_oe = 1'b0;
              q_nxt.st     = S_WR;
            end
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (q_r.cnt == LAST_TX_SHIFT) begin
              q_nxt.sda_oe = 1'b0;
              q_nxt.st     = S_RACK;
            end else begin
              q_nxt.sda_oe = ~q_r.sh[6];
              q_nxt.sh     = {q_r.sh[6:0], 1'b0};
              q_nxt.cnt    = q_r.cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise && smp.sda) begin
            q_nxt.st = S_IDLE;
          end else if (scl_fall) begin
            q_nxt.cnt    = 4'h0;
            q_nxt.sh     = rd_val;
            q_nxt.sda_oe = ~rd_val[7];
            q_nxt.st     = S_RD;
          end
        end
        default: begin
          q_nxt.st     = S_IDLE;
          q_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= CORE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o        = 1'b0;
  assign sda_oe_o     = q_r.sda_oe;
  assign gpio_o       = q_r.regs.out_latch;
  assign gpio_oe_o    = ~q_r.regs.direction;
  assign drive_code_o = {q_r.regs.drive_hi, q_r.regs.drive_lo};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  property p_in_live;
    rd_load && (q_r.ptr == PTR_IN) |=> q_r.sh == $past(sensed);
  endproperty
  a_in_live: assert property (p_in_live) else $error("input read not live");

  property p_in_ro;
    reg_wr && (q_r.ptr == PTR_IN) |=> $stable(q_r.regs) && $stable(gpio_o) && $stable(gpio_oe_o);
  endproperty
  a_in_ro: assert property (p_in_ro) else $error("write to input register had effect");

  // Synchroniser plus agreement filter needs five steady samples of the pins, the current one and four before it
  property p_in_follow;
    $past(rstn_i, 4) && (q_r.regs.invert == 8'h00) && (gpio_i == $past(gpio_i))
      && (gpio_i == $past(gpio_i, 2)) && (gpio_i == $past(gpio_i, 3))
      && (gpio_i == $past(gpio_i, 4)) |-> sensed == gpio_i;
  endproperty
  a_in_follow: assert property (p_in_follow) else $error("input value not from pins");

  property p_out_wr;
    reg_wr && (q_r.ptr == PTR_OUT)
      |=> (gpio_o & gpio_oe_o) == ($past(q_r.sh) & ~q_r.regs.direction);
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output latch not driven");

  property p_out_rd;
    rd_load && (q_r.ptr == PTR_OUT) |=> q_r.sh == $past(q_r.regs.out_latch);
  endproperty
  a_out_rd: assert property (p_out_rd) else $error("latch read not write value");

  property p_invert;
    rd_load && (q_r.ptr == PTR_IN)
      |=> q_r.sh == ($past(smp.pins) ^ ($past(q_r.regs.invert) & $past(q_r.regs.direction)));
  endproperty
  a_invert: assert property (p_invert) else $error("inversion misapplied");

  property p_dir_wr;
    reg_wr && (q_r.ptr == PTR_DIR) |=> gpio_oe_o == ~$past(q_r.sh);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction not applied");

  property p_drive_wr;
    reg_wr && (q_r.ptr == PTR_DRV_HI) |=> drive_code_o[15:14] == $past(q_r.sh[7:6]);
  endproperty
  a_drive_wr: assert property (p_drive_wr) else $error("pin 7 drive code misplaced");

  property p_ptr_wr;
    ptr_wr |=> q_r.ptr == $past(q_r.sh) && q_r.got_cmd && q_r.sda_oe;
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("pointer not stored");

  property p_rw_bit;
    (q_r.st == S_ADDR) && byte_done && addr_hit |=> q_r.rw == $past(q_r.sh[0]) && q_r.st == S_ACK;
  endproperty
  a_rw_bit: assert property (p_rw_bit) else $error("direction bit not taken");

  property p_addr_miss;
    (q_r.st == S_ADDR) && byte_done && !addr_hit && !start_cond && !stop_cond
      |=> q_r.st == S_IDLE && !sda_oe_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("answered foreign address");

  property p_addr_ack;
    (q_r.st == S_ADDR) && byte_done && addr_hit |=> sda_oe_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_rd_nack;
    (q_r.st == S_RACK) && scl_rise && smp.sda |=> q_r.st == S_IDLE && !sda_oe_o;
  endproperty
  a_rd_nack: assert property (p_rd_nack) else $error("read kept going after nack");

  // Pointer persists, so every byte of one read comes from the same register
  property p_rd_again;
    (q_r.st == S_RACK) && scl_fall |=> q_r.st == S_RD && q_r.sh == $past(rd_val);
  endproperty
  a_rd_again: assert property (p_rd_again) else $error("next read byte not reloaded");

endmodule

// [tb/i2c_host_model.sv]
// Purpose: Behavioural bus host that reads and writes expander registers
// Assumes: Open-drain data line with pull-up; device pull given on dev_pull_i
// Notes:   Clock line stands high between frames; each phase is 8 system clocks
`timescale 1ns/1ns
module i2c_host_model (
  input  wire logic clk_sys_i,
  input  wire logic dev_pull_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic sda_drv;

  // Released line floats to the pull-up level
  assign sda_o = sda_drv & ~dev_pull_i;

  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hp;
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask

  // Also serves as repeated start: data is raised while clock is low
  task automatic start_c;
    sda_drv = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl_o = 1'b0;
    hp;
  endtask

  task automatic stop_c;
    sda_drv = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  endtask

  // Data held through the whole high phase, sampled at its end
  task automatic xbit(input logic b, output logic r);
    sda_drv = b;
    hp;
    scl_o = 1'b1;
    hp;
    r = sda_o;
    scl_o = 1'b0;
    hp;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
                       output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(m, a);
  endtask

  task automatic access(input logic [6:0] dev, input logic rd, input logic [7:0] ptr,
                        input logic [7:0] wd, output logic [7:0] rdat, output logic nak);
    logic [7:0] q;
    logic       a;
    rdat = 8'h00;
    start_c;
    xbyte({dev, 1'b0}, 1'b1, q, nak);
    if (!nak) begin
      xbyte(ptr, 1'b1, q, a);
      if (rd) begin
        start_c;
        xbyte({dev, 1'b1}, 1'b1, q, a);
        xbyte(8'hff, 1'b1, rdat, a);
      end else begin
        xbyte(wd, 1'b1, q, a);
      end
    end
    stop_c;
  endtask

  // Two bytes in one read: the host acknowledges the first, refuses the second
  task automatic read2(input logic [6:0] dev, input logic [7:0] ptr,
                       output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] q;
    logic       a;
    start_c;
    xbyte({dev, 1'b0}, 1'b1, q, a);
    xbyte(ptr, 1'b1, q, a);
    start_c;
    xbyte({dev, 1'b1}, 1'b1, q, a);
    xbyte(8'hff, 1'b0, r0, a);
    xbyte(8'hff, 1'b1, r1, a);
    stop_c;
  endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the expander register core
// Assumes: Host model drives the bus; bench drives pins and address selects
// Notes:   Each acknowledged access is a full frame, so the pointer is always rewritten
`timescale 1ns/1ns
module tb_top;
  import gpx_pkg::*;

  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        scl;
  logic        sda;
  logic        sda_o;
  logic        sda_oe;
  logic        a0 = 1'b0;
  logic        a1 = 1'b0;
  logic [7:0]  gpio_in = 8'h3c;
  logic [7:0]  gpio_o;
  logic [7:0]  gpio_oe;
  logic [15:0] drive_code;
  logic [15:0] snap;
  logic [7:0]  rd;
  logic [7:0]  rd2;
  logic        nak;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [7:0]  ptr_tab [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h41,
                                8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4f};
  logic [7:0]  exp_tab [12] = '{8'h3c, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
                                8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

  always #5 clk_sys_i = ~clk_sys_i;

  i2c_gpio_expander_regs i_dut (
    .clk_sys_i          (clk_sys_i),
    .rstn_i             (rstn_i),
    .scl_i              (scl),
    .sda_i              (sda),
    .sda_o              (sda_o),
    .sda_oe_o           (sda_oe),
    .addr_select_bit0_i (a0),
    .addr_select_bit1_i (a1),
    .gpio_i             (gpio_in),
    .gpio_o             (gpio_o),
    .gpio_oe_o          (gpio_oe),
    .drive_code_o       (drive_code)
  );

  i2c_host_model i_host (
    .clk_sys_i  (clk_sys_i),
    .dev_pull_i (sda_oe & ~sda_o),
    .scl_o      (scl),
    .sda_o      (sda)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.access({5'h1c, a1, a0}, 1'b0, p, d, rd, nak);
    chk({15'h0000, nak}, 16'h0000);
  endtask

  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    i_host.access({5'h1c, a1, a0}, 1'b1, p, 8'h00, rd, nak);
    chk({nak, 7'h00, rd}, {8'h00, exp});
  endtask

  task automatic read_all;
    for (int i = 0; i < 12; i++) rdc(ptr_tab[i], exp_tab[i]);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      $display("FAIL t=%0t run did not finish", $time);
      wrap_up;
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk({gpio_o, gpio_oe}, 16'hff00);
    rstn_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk(drive_code, 16'hffff);
    read_all;
    $display("test reset values done");
    for (int i = 1; i < 12; i++) begin
      wr(ptr_tab[i], 8'(8'h11 * i));
      exp_tab[i] = 8'(8'h11 * i);
    end
    exp_tab[10] = 8'h00;
    exp_tab[11] = 8'hbb & OSTAGE_MASK;
    exp_tab[0] = gpio_in ^ (exp_tab[2] & exp_tab[3]);
    snap = drive_code;
    wr(8'h00, 8'ha5);
    chk(drive_code, snap);
    chk({gpio_o, gpio_oe}, {8'h11, ~8'h33});
    read_all;
    $display("test register access done");
    wr(8'h03, 8'h0f);
    wr(8'h01, 8'h5a);
    wr(8'h02, 8'hff);
    chk({8'h00, gpio_oe}, 16'h00f0);
    chk({8'h00, gpio_o & gpio_oe}, 16'h0050);
    rdc(8'h01, 8'h5a);
    rdc(8'h00, 8'h33);
    wr(8'h02, 8'h00);
    gpio_in = 8'hc3;
    rdc(8'h00, 8'hc3);
    $display("test pins done");
    wr(8'h40, 8'he4);
    wr(8'h41, 8'h1b);
    chk(drive_code, 16'h1be4);
    chk({14'h0000, drive_code[15:14]}, 16'h0000);
    i_host.read2({5'h1c, a1, a0}, 8'h41, rd, rd2);
    chk({rd, rd2}, 16'h1b1b);
    $display("test drive codes done");
    a1 = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    i_host.access(7'h70, 1'b1, 8'h01, 8'h00, rd, nak);
    chk({15'h0000, nak}, 16'h0001);
    rdc(8'h41, 8'h1b);
    wr(8'h10, 8'h77);
    rdc(8'h10, 8'h00);
    $display("test addressing done");
    wrap_up;
  end
endmodule
